// ### vector_crypto_pkg.sv
// Purpose: shared constants and types of the vector crypto unit
// Assumes: 128-bit vectors, byte 0 and element 0 in the top bits
// Notes: op codes are local encodings of the issue pipeline
package vector_crypto_pkg;

  localparam int VEC_W = 128;
  localparam int SCR_W = 32;
  localparam int RESULT_LATENCY = 1;

  typedef enum logic [3:0] {
    OP_PMSUM = 4'h0,
    OP_SIGMA32 = 4'h1,
    OP_SIGMA64 = 4'h2,
    OP_SBOX = 4'h3,
    OP_ENC = 4'h4,
    OP_ENC_LAST = 4'h5,
    OP_DEC = 4'h6,
    OP_DEC_LAST = 4'h7,
    OP_SCR_WRITE = 4'h8,
    OP_SCR_READ = 4'h9
  } vec_op_e;

  // source element width of the pair-summing multiply
  localparam logic [1:0] PM_BYTE = 2'h0;
  localparam logic [1:0] PM_HALF = 2'h1;
  localparam logic [1:0] PM_WORD = 2'h2;
  localparam logic [1:0] PM_DWORD = 2'h3;

  localparam logic [7:0] AES_POLY = 8'h1b;
  localparam logic [7:0] AES_AFFINE_C = 8'h63;
  localparam logic [7:0] AES_INV_AFFINE_C = 8'h05;

  localparam logic [31:0] SCR_RESET = 32'h0000_0000;

endpackage : vector_crypto_pkg

// ### aes_round_core.sv
// Purpose: combinational aes round step (sub-bytes only, round, final round)
// Assumes: state byte k sits in bits [127-8k -: 8], column c is bytes 4c..4c+3
// Notes: s-box is computed, not tabled, to keep the source small
`timescale 1ns/10ps
`default_nettype none
module aes_round_core
  import vector_crypto_pkg::*;
(
  input wire logic [127:0] state_i,
  input wire logic [127:0] key_i,
  input wire logic inverse_i,
  input wire logic final_i,
  input wire logic sub_only_i,
  output logic [127:0] state_o
);

  function automatic logic [7:0] xtime(input logic [7:0] b);
    return {b[6:0], 1'b0} ^ (b[7] ? AES_POLY : 8'h00);
  endfunction : xtime

  function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r;
    logic [7:0] p;
    r = 8'h00;
    p = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) begin
        r = r ^ p;
      end
      p = xtime(p);
    end
    return r;
  endfunction : gf_mul

  // x^254, which also maps zero to zero
  function automatic logic [7:0] gf_inv(input logic [7:0] x);
    logic [7:0] sq;
    logic [7:0] r;
    sq = x;
    r = 8'h01;
    for (int k = 1; k < 8; k++) begin
      sq = gf_mul(sq, sq);
      r = gf_mul(r, sq);
    end
    return r;
  endfunction : gf_inv

  function automatic logic [7:0] rotl8(input logic [7:0] b, input int n);
    return 8'((b << n) | (b >> (8 - n)));
  endfunction : rotl8

  function automatic logic [7:0] sub_byte(input logic [7:0] b);
    logic [7:0] v;
    v = gf_inv(b);
    return v ^ rotl8(v, 1) ^ rotl8(v, 2) ^ rotl8(v, 3) ^ rotl8(v, 4) ^ AES_AFFINE_C;
  endfunction : sub_byte

  function automatic logic [7:0] inv_sub_byte(input logic [7:0] b);
    return gf_inv(rotl8(b, 1) ^ rotl8(b, 3) ^ rotl8(b, 6) ^ AES_INV_AFFINE_C);
  endfunction : inv_sub_byte

  logic [7:0] s [16];
  logic [7:0] t [16];
  logic [7:0] u [16];
  logic [7:0] m [16];

  always_comb begin
    int src;
    int idx;
    src = 0;
    idx = 0;
    for (int k = 0; k < 16; k++) begin
      s[k] = state_i[127 - 8 * k -: 8];
    end
    // row shift folded into the substitution index
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        idx = 4 * c + r;
        if (sub_only_i) begin
          src = idx;
        end else if (inverse_i) begin
          src = 4 * ((c - r + 4) % 4) + r;
        end else begin
          src = 4 * ((c + r) % 4) + r;
        end
        t[idx] = (inverse_i && !sub_only_i) ? inv_sub_byte(s[src]) : sub_byte(s[src]);
      end
    end
    // inverse round adds the key before the column mix
    for (int k = 0; k < 16; k++) begin
      u[k] = (inverse_i && !sub_only_i) ? t[k] ^ key_i[127 - 8 * k -: 8] : t[k];
    end
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        if (final_i || sub_only_i) begin
          m[4 * c + r] = u[4 * c + r];
        end else if (inverse_i) begin
          m[4 * c + r] = gf_mul(u[4 * c + r], 8'h0e) ^ gf_mul(u[4 * c + (r + 1) % 4], 8'h0b)
                       ^ gf_mul(u[4 * c + (r + 2) % 4], 8'h0d)
                       ^ gf_mul(u[4 * c + (r + 3) % 4], 8'h09);
        end else begin
          m[4 * c + r] = xtime(u[4 * c + r]) ^ xtime(u[4 * c + (r + 1) % 4])
                       ^ u[4 * c + (r + 1) % 4] ^ u[4 * c + (r + 2) % 4]
                       ^ u[4 * c + (r + 3) % 4];
        end
      end
    end
    for (int k = 0; k < 16; k++) begin
      state_o[127 - 8 * k -: 8] = (!inverse_i && !sub_only_i) ?
                                  m[k] ^ key_i[127 - 8 * k -: 8] : m[k];
    end
  end

endmodule : aes_round_core
`default_nettype wire

// ### vector_crypto_unit.sv
// Purpose: vector crypto execution unit: carry-less multiply, sha sigma, aes, status reg
// Assumes: operands arrive already in big-endian layout from the issue pipeline
// Notes: one request per cycle, result one cycle after the request
//
// Summary of operation
// - result element is xor of even/odd carry-less products
// - widths byte, half, word, dword to double width
// - 32-bit sigma: type picks small/capital, mask bit i variant
// - 64-bit sigma: same type rule, mask bit 2i
// - sbox substitutes every byte of the state
// - forward round: one full aes encryption round
// - forward final round: last encryption round
// - inverse round: one aes decryption round
// - inverse final round: last decryption round
// - status write loads low 32 operand bits
// - status read: upper half to halfword 6, lower 7
// - all operands and results are big-endian
`timescale 1ns/10ps
`default_nettype none
module vector_crypto_unit
  import vector_crypto_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic req_valid_i,
  input wire vec_op_e req_op_i,
  input wire logic [1:0] pm_width_i,
  input wire logic [VEC_W-1:0] src_a_i,
  input wire logic [VEC_W-1:0] src_b_i,
  input wire logic [31:0] sigma_type_select_i,
  input wire logic [3:0] sigma_variant_mask_i,
  output logic req_ready_o,
  output logic result_valid_o,
  output logic [VEC_W-1:0] result_o,
  output logic [SCR_W-1:0] vector_status_control_o
);

  typedef struct packed {
    logic [VEC_W-1:0] result;
    logic valid;
    logic [SCR_W-1:0] scr;
  } unit_state_s;

  localparam unit_state_s RESET_STATE = '{result: '0, valid: 1'b0, scr: SCR_RESET};

  unit_state_s state_reg;
  unit_state_s state_next;
  logic [VEC_W-1:0] aes_out;

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic helpers

  function automatic logic [31:0] sigma32(input logic [31:0] x, input logic cap,
                                          input logic var1);
    logic [31:0] r;
    case ({cap, var1})
      2'b00: r = {x[6:0], x[31:7]} ^ {x[17:0], x[31:18]} ^ (x >> 3);
      2'b01: r = {x[16:0], x[31:17]} ^ {x[18:0], x[31:19]} ^ (x >> 10);
      2'b10: r = {x[1:0], x[31:2]} ^ {x[12:0], x[31:13]} ^ {x[21:0], x[31:22]};
      default: r = {x[5:0], x[31:6]} ^ {x[10:0], x[31:11]} ^ {x[24:0], x[31:25]};
    endcase
    return r;
  endfunction : sigma32

  function automatic logic [63:0] sigma64(input logic [63:0] x, input logic cap,
                                          input logic var1);
    logic [63:0] r;
    case ({cap, var1})
      2'b00: r = {x[0], x[63:1]} ^ {x[7:0], x[63:8]} ^ (x >> 7);
      2'b01: r = {x[18:0], x[63:19]} ^ {x[60:0], x[63:61]} ^ (x >> 6);
      2'b10: r = {x[27:0], x[63:28]} ^ {x[33:0], x[63:34]} ^ {x[38:0], x[63:39]};
      default: r = {x[13:0], x[63:14]} ^ {x[17:0], x[63:18]} ^ {x[40:0], x[63:41]};
    endcase
    return r;
  endfunction : sigma64

  function automatic logic [127:0] clmul64(input logic [63:0] a, input logic [63:0] b);
    logic [127:0] r;
    r = '0;
    for (int i = 0; i < 64; i++) begin
      if (b[i]) begin
        r = r ^ ({64'h0, a} << i);
      end
    end
    return r;
  endfunction : clmul64

  // element 0 is the most significant slice of the vector
  function automatic logic [127:0] pmsum(input logic [127:0] a, input logic [127:0] b,
                                         input logic [1:0] wsel);
    int w;
    logic [63:0] msk;
    logic [63:0] a0;
    logic [63:0] b0;
    logic [63:0] a1;
    logic [63:0] b1;
    logic [127:0] r;
    w = 8 << wsel;
    msk = (wsel == PM_DWORD) ? 64'hffff_ffff_ffff_ffff : (64'h1 << w) - 64'h1;
    r = '0;
    for (int j = 0; j < 8; j++) begin
      if (j < 64 / w) begin
        a0 = 64'(a >> (128 - (2 * j + 1) * w)) & msk;
        b0 = 64'(b >> (128 - (2 * j + 1) * w)) & msk;
        a1 = 64'(a >> (128 - (2 * j + 2) * w)) & msk;
        b1 = 64'(b >> (128 - (2 * j + 2) * w)) & msk;
        r = r | ((clmul64(a0, b0) ^ clmul64(a1, b1)) << (128 - (j + 1) * 2 * w));
      end
    end
    return r;
  endfunction : pmsum

  ////////////////////////////////////////////////////////////////////////////
  // aes datapath

  aes_round_core aes_round_core_inst (
    .state_i(src_a_i),
    .key_i(src_b_i),
    .inverse_i(req_op_i == OP_DEC || req_op_i == OP_DEC_LAST),
    .final_i(req_op_i == OP_ENC_LAST || req_op_i == OP_DEC_LAST),
    .sub_only_i(req_op_i == OP_SBOX),
    .state_o(aes_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic cap;
    cap = (sigma_type_select_i != 32'h0);
    state_next = state_reg;
    state_next.valid = req_valid_i;
    if (req_valid_i) begin
      case (req_op_i)
        OP_PMSUM: state_next.result = pmsum(src_a_i, src_b_i, pm_width_i);
        OP_SIGMA32: begin
          for (int i = 0; i < 4; i++) begin
            state_next.result[127 - 32 * i -: 32] =
              sigma32(src_a_i[127 - 32 * i -: 32], cap, sigma_variant_mask_i[i]);
          end
        end
        OP_SIGMA64: begin
          for (int i = 0; i < 2; i++) begin
            state_next.result[127 - 64 * i -: 64] =
              sigma64(src_a_i[127 - 64 * i -: 64], cap, sigma_variant_mask_i[2 * i]);
          end
        end
        OP_SBOX, OP_ENC, OP_ENC_LAST, OP_DEC, OP_DEC_LAST: state_next.result = aes_out;
        OP_SCR_WRITE: begin
          state_next.scr = src_a_i[SCR_W-1:0];
          state_next.result = '0;
        end
        OP_SCR_READ: state_next.result = {96'h0, state_reg.scr};
        default: state_next.result = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= RESET_STATE;
    end else begin
      state_reg <= state_next;
    end
  end

  // no internal queue, so the unit never stalls the issuer
  assign req_ready_o = 1'b1;
  assign result_valid_o = state_reg.valid;
  assign result_o = state_reg.result;
  assign vector_status_control_o = state_reg.scr;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  a_result_latency: assert property (req_valid_i |=> result_valid_o ##0 $past(req_valid_i))
    else $error("result valid not one cycle after request");
  a_scr_write_load: assert property (req_valid_i && req_op_i == OP_SCR_WRITE |=>
    vector_status_control_o == $past(src_a_i[31:0])) else $error("status write lost");
  a_scr_hold: assert property (!(req_valid_i && req_op_i == OP_SCR_WRITE) |=>
    $stable(vector_status_control_o)) else $error("status changed without a write");
  a_scr_read_layout: assert property (req_valid_i && req_op_i == OP_SCR_READ |=>
    result_o[127:32] == 96'h0 && result_o[31:16] == $past(vector_status_control_o[31:16])
    && result_o[15:0] == $past(vector_status_control_o[15:0]))
    else $error("status read layout wrong");
  a_sbox_zero: assert property (req_valid_i && req_op_i == OP_SBOX
    && src_a_i == 128'h0 |=> result_o == {16{AES_AFFINE_C}}) else $error("sbox of zero wrong");
  a_enc_round_zero: assert property (req_valid_i && req_op_i == OP_ENC
    && src_a_i == 128'h0 |=> result_o == ({16{8'h63}} ^ $past(src_b_i)))
    else $error("encrypt round wrong");
  a_enc_final_key: assert property (req_valid_i && req_op_i == OP_ENC_LAST
    && src_a_i == 128'h0 |=> result_o == ({16{8'h63}} ^ $past(src_b_i)))
    else $error("encrypt final round wrong");
  a_dec_round_zero: assert property (req_valid_i && req_op_i == OP_DEC
    && src_a_i == {16{8'h63}} && src_b_i == 128'h0 |=> result_o == 128'h0)
    else $error("decrypt round wrong");
  a_dec_final_key: assert property (req_valid_i && req_op_i == OP_DEC_LAST
    && src_a_i == {16{8'h63}} |=> result_o == $past(src_b_i))
    else $error("decrypt final round wrong");
  a_sigma32_elem: assert property (req_valid_i && req_op_i == OP_SIGMA32 |=>
    result_o[31:0] == sigma32($past(src_a_i[31:0]), $past(sigma_type_select_i) != 32'h0,
    $past(sigma_variant_mask_i[3]))) else $error("sigma32 last element wrong");
  a_sigma64_elem: assert property (req_valid_i && req_op_i == OP_SIGMA64 |=>
    result_o[63:0] == sigma64($past(src_a_i[63:0]), $past(sigma_type_select_i) != 32'h0,
    $past(sigma_variant_mask_i[2]))) else $error("sigma64 element 1 wrong");
  a_pmsum_dword: assert property (req_valid_i && req_op_i == OP_PMSUM
    && pm_width_i == PM_DWORD |=> result_o == (clmul64($past(src_a_i[127:64]),
    $past(src_b_i[127:64])) ^ clmul64($past(src_a_i[63:0]), $past(src_b_i[63:0]))))
    else $error("pair sum multiply wrong");
  a_pmsum_byte: assert property (req_valid_i && req_op_i == OP_PMSUM
    && pm_width_i == PM_BYTE |=> result_o[127:112] == 16'(clmul64(
    {56'h0, $past(src_a_i[127:120])}, {56'h0, $past(src_b_i[127:120])}) ^ clmul64(
    {56'h0, $past(src_a_i[119:112])}, {56'h0, $past(src_b_i[119:112])})))
    else $error("byte pair sum wrong");

  c_pmsum_word: cover property (req_valid_i && req_op_i == OP_PMSUM && pm_width_i == PM_WORD);
  c_sigma_capital: cover property (req_valid_i && req_op_i == OP_SIGMA64
    && sigma_type_select_i != 32'h0);
  c_dec_round: cover property (req_valid_i && req_op_i == OP_DEC);
  c_scr_roundtrip: cover property (req_valid_i && req_op_i == OP_SCR_WRITE
    ##1 req_valid_i && req_op_i == OP_SCR_READ);

endmodule : vector_crypto_unit
`default_nettype wire

// ### core_issue_model.sv
// Purpose: issue-side model of the core feeding the vector crypto unit
// Assumes: caller stands one small delay past a rising clock edge
// Notes: operands are scrambled while idle so stale values never pass
`timescale 1ns/10ps
`default_nettype none
module core_issue_model
  import vector_crypto_pkg::*;
(
  input wire logic clk_i,
  input wire logic result_valid_i,
  input wire logic [VEC_W-1:0] result_i,
  output logic req_valid_o,
  output vec_op_e req_op_o,
  output logic [1:0] pm_width_o,
  output logic [VEC_W-1:0] src_a_o,
  output logic [VEC_W-1:0] src_b_o,
  output logic [31:0] sigma_type_o,
  output logic [3:0] sigma_mask_o
);
  initial begin
    req_valid_o = 1'b0;
    req_op_o = OP_PMSUM;
    {pm_width_o, src_a_o, src_b_o, sigma_type_o, sigma_mask_o} = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // request stays up; the answer is read one edge later
  task automatic issue(input vec_op_e op, input logic [1:0] w, input logic [127:0] a,
      input logic [127:0] b, input logic [31:0] t, input logic [3:0] m,
      output logic [127:0] res, output logic vld);
    req_valid_o = 1'b1;
    req_op_o = op;
    pm_width_o = w;
    src_a_o = a;
    src_b_o = b;
    sigma_type_o = t;
    sigma_mask_o = m;
    @(posedge clk_i);
    #1;
    res = result_i;
    vld = result_valid_i;
  endtask : issue

  task automatic idle();
    req_valid_o = 1'b0;
    src_a_o = ~src_a_o;
    src_b_o = ~src_b_o;
  endtask : idle
endmodule : core_issue_model
`default_nettype wire

// ### vector_crypto_unit_tb.sv
// Purpose: self-checking bench of the vector crypto unit
// Assumes: one-cycle answer, inputs moved 1 ns after the rising edge
// Notes: aes expectations chain known round values, no aes model here
`timescale 1ns/10ps
`default_nettype none
module vector_crypto_unit_tb;
  import vector_crypto_pkg::*;
  localparam logic [127:0] S_IN = 128'h193de3bea0f4e22b9ac68d2ae9f84808;
  localparam logic [127:0] S_SUB = 128'hd42711aee0bf98f1b8b45de51e415230;
  localparam logic [127:0] S_SHF = 128'hd4bf5d30e0b452aeb84111f11e2798e5;
  localparam logic [127:0] S_MIX = 128'h046681e5e0cb199a48f8d37a2806264c;
  localparam logic [127:0] K1 = 128'ha0fafe1788542cb123a339392a6c7605;
  localparam logic [127:0] S_R2 = 128'ha49c7ff2689f352b6b5bea43026a5049;
  localparam logic [127:0] A = 128'h0123456789abcdeffedcba9876543210;
  localparam logic [127:0] B = 128'h8badf00d1234567890fedcba0f1e2d3c;
  logic core_clk, nrst, req_valid, ready, rvld, vld;
  vec_op_e req_op;
  logic [1:0] pm_width;
  logic [127:0] src_a, src_b, result, res;
  logic [31:0] sig_type, scr;
  logic [3:0] sig_mask;
  int fails, n_tests, cyc;

  vector_crypto_unit vector_crypto_unit_inst (.core_clk_i(core_clk), .nrst_i(nrst),
    .req_valid_i(req_valid), .req_op_i(req_op), .pm_width_i(pm_width), .src_a_i(src_a),
    .src_b_i(src_b), .sigma_type_select_i(sig_type), .sigma_variant_mask_i(sig_mask),
    .req_ready_o(ready), .result_valid_o(rvld), .result_o(result),
    .vector_status_control_o(scr));
  core_issue_model core_issue_model_inst (.clk_i(core_clk), .result_valid_i(rvld),
    .result_i(result), .req_valid_o(req_valid), .req_op_o(req_op), .pm_width_o(pm_width),
    .src_a_o(src_a), .src_b_o(src_b), .sigma_type_o(sig_type), .sigma_mask_o(sig_mask));

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;
  // whole run is under 100 cycles; this only cuts a hang
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [127:0] clmul(logic [127:0] x, logic [127:0] y);
    clmul = '0;
    for (int i = 0; i < 64; i++) if (y[i]) clmul ^= x << i;
  endfunction : clmul

  function automatic logic [127:0] pm_exp(int w);
    logic [127:0] r, m, p;
    int k;
    r = '0;
    m = (128'h1 << w) - 128'h1;
    for (int j = 0; j < 64 / w; j++) begin
      p = '0;
      for (int e = 0; e < 2; e++) begin
        k = 128 - (2 * j + e + 1) * w;
        p ^= clmul((A >> k) & m, (B >> k) & m);
      end
      r |= p << (128 - (j + 1) * 2 * w);
    end
    return r;
  endfunction : pm_exp

  function automatic logic [63:0] rr(logic [63:0] x, int s, int w);
    return ((x >> s) | (x << (w - s))) & ((w == 64) ? 64'hffffffffffffffff : 64'hffffffff);
  endfunction : rr

  function automatic logic [63:0] sg(logic [63:0] x, int w, bit cap, bit v);
    int n[3];
    case ({w == 64, cap, v})
      3'b000: n = '{7, 18, 3};
      3'b001: n = '{17, 19, 10};
      3'b010: n = '{2, 13, 22};
      3'b011: n = '{6, 11, 25};
      3'b100: n = '{1, 8, 7};
      3'b101: n = '{19, 61, 6};
      3'b110: n = '{28, 34, 39};
      default: n = '{14, 18, 41};
    endcase
    return rr(x, n[0], w) ^ rr(x, n[1], w) ^ (cap ? rr(x, n[2], w) : x >> n[2]);
  endfunction : sg

  function automatic logic [127:0] sig_exp(int w, bit cap, logic [3:0] m);
    logic [127:0] r;
    int k;
    r = '0;
    for (int i = 0; i < 128 / w; i++) begin
      k = 128 - (i + 1) * w;
      r |= {64'h0, sg(64'((A >> k) & ((128'h1 << w) - 128'h1)), w, cap,
        (w == 64) ? m[2 * i] : m[i])} << k;
    end
    return r;
  endfunction : sig_exp

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic run(input string nm, input vec_op_e op, input logic [1:0] w,
      input logic [127:0] a, input logic [127:0] b, input logic [31:0] t,
      input logic [3:0] m, input logic [127:0] e);
    core_issue_model_inst.issue(op, w, a, b, t, m, res, vld);
    chk({nm, " valid"}, 128'h1, {127'h0, vld});
    chk(nm, e, res);
  endtask : run

  task automatic t_pmsum();
    for (int w = 0; w < 4; w++) begin
      run("pmsum", OP_PMSUM, 2'(w), A, B, '0, '0, pm_exp(8 << w));
    end
    $display("test pmsum done");
  endtask : t_pmsum

  task automatic t_sigma();
    logic [3:0] ms[2] = '{4'h3, 4'hc};
    logic [31:0] ts;
    logic [31:0] t64;
    bit cp;
    for (int c = 0; c < 2; c++) begin
      ts = c ? 32'h80000000 : 32'h0;
      t64 = c ? 32'h1 : 32'h0;
      cp = (c != 0);
      for (int i = 0; i < 2; i++) begin
        run("sigma32", OP_SIGMA32, '0, A, B, ts, ms[i], sig_exp(32, cp, ms[i]));
        run("sigma64", OP_SIGMA64, '0, A, B, t64, ms[i], sig_exp(64, cp, ms[i]));
      end
    end
    $display("test sigma done");
  endtask : t_sigma

  task automatic t_aes();
    run("sbox", OP_SBOX, '0, S_IN, K1, '0, '0, S_SUB);
    run("enc", OP_ENC, '0, S_IN, K1, '0, '0, S_R2);
    run("enc last", OP_ENC_LAST, '0, S_IN, K1, '0, '0, S_SHF ^ K1);
    run("dec", OP_DEC, '0, S_SHF, S_IN ^ S_MIX, '0, '0, S_SHF);
    run("dec last", OP_DEC_LAST, '0, S_SHF, K1, '0, '0, S_IN ^ K1);
    $display("test aes done");
  endtask : t_aes

  task automatic t_scr();
    run("scr write", OP_SCR_WRITE, '0, {96'h5a5a5a5a_a5a5a5a5_ffffffff, 32'hcafe1234}, B,
      '0, '0, '0);
    chk("scr port", 128'hcafe1234, {96'h0, scr});
    run("scr read", OP_SCR_READ, '0, A, B, '0, '0, {96'h0, 32'hcafe1234});
    run("bad op", vec_op_e'(4'hf), '0, A, B, '0, '0, '0);
    core_issue_model_inst.idle();
    @(posedge core_clk);
    #1;
    chk("valid drop", 128'h0, {127'h0, rvld});
    chk("scr hold", 128'hcafe1234, {96'h0, scr});
    $display("test scr done");
  endtask : t_scr

  // the second reset is applied 1 ns after an edge, so it also hits a unit in mid-run
  task automatic t_reset(input int n);
    nrst = 1'b0;
    repeat (n) @(posedge core_clk);
    #1;
    chk("reset valid", 128'h0, {127'h0, rvld});
    chk("reset result", 128'h0, result);
    chk("reset scr", {96'h0, SCR_RESET}, {96'h0, scr});
    chk("reset ready", 128'h1, {127'h0, ready});
    nrst = 1'b1;
    $display("test reset done");
  endtask : t_reset

  task automatic t_reset_mid();
    t_reset(1);
    run("scr cleared", OP_SCR_READ, '0, A, B, '0, '0, {96'h0, SCR_RESET});
    $display("test mid reset done");
  endtask : t_reset_mid

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    t_reset(6);
    t_pmsum();
    t_sigma();
    t_aes();
    t_scr();
    t_reset_mid();
    report_and_stop();
  end
endmodule : vector_crypto_unit_tb
`default_nettype wire
